// [core/power_button_wake_sequencer.sv]
/*
 Power state sequencer: switch hold timing, wake sources, software
 commands over APB, fan control, rail window monitor, intrusion flag.
 Assumes pins are asynchronous, sensor words come from logic on sys_clk_in.
*/
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
module power_button_wake_sequencer #(
  parameter int unsigned SHORT_HOLD = pwr_seq_pkg::SHORT_CYC,
  parameter int unsigned LONG_HOLD  = pwr_seq_pkg::LONG_CYC
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      pwr_btn_n_in,
  input  wire pwr_seq_pkg::wake_pins_type wake_pins_in,
  input  wire logic                      chassis_closed_in,
  input  wire logic [2:0][7:0]           fan_temp_in,
  input  wire logic [4:0][7:0]           rail_level_in,
  output pwr_seq_pkg::pwr_state_type     state_out,
  output pwr_seq_pkg::pwr_ctl_type       pwr_ctl_out,
  output logic      [2:0]                fan_pwm_out,
  output logic                           irq_out
);
  import pwr_seq_pkg::*;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic is_sleep(input pwr_state_type s);
    is_sleep = (s == ST_S1) || (s == ST_S3) || (s == ST_S4);
  endfunction

  function automatic logic wake_gate(input pwr_state_type s, input logic s4_ok);
    wake_gate = (s == ST_S4) ? s4_ok : 1'b1;
  endfunction

  function automatic logic [7:0] fan_duty(input logic [7:0] t, input logic [7:0] on);
    logic [9:0] d;
    d = 10'((t - on)) << FAN_GAIN;
    if (t < on)
      fan_duty = 8'h00_00;
    else if (d > 10'h00_FF)
      fan_duty = 8'h00_FF;
    else
      fan_duty = d[7:0];
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic          btn_n_s;
  logic          chassis_s;
  wake_pins_type wake_s;

  sync_2ff #(.W(8)) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({pwr_btn_n_in, chassis_closed_in, wake_pins_in}),
    .rst_val_in (8'h86),
    .sync_out   ({btn_n_s, chassis_s, wake_s})
  );

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  pwr_state_type     state_r;
  logic [7:0]        ctrl_r;
  logic [7:0]        fan_on_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_en_r;
  logic [HOLD_W-1:0] hold_r;
  logic              btn_q_r;
  logic              long_done_r;
  logic [RAILS-1:0]  rail_bad;
  logic              wr_en;
  logic              rd_en;
  logic              mapped;
  logic              cmd_wr;
  pwr_state_type     cmd_state;
  pwr_state_type     slp_sel;
  pwr_state_type     state_nxt;
  logic [IRQ_W-1:0]  irq_set;
  logic              btn;
  logic              short_rel;
  logic              long_hit;
  logic              wake_any;

  assign btn       = ~btn_n_s;
  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & ~penable & ~pwrite;
  assign mapped    = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
                     (paddr == OFS_STATUS) || (paddr == OFS_IRQ_STAT) ||
                     (paddr == OFS_IRQ_CLR) || (paddr == OFS_IRQ_EN) ||
                     (paddr == OFS_FAN_CFG);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign cmd_wr    = wr_en & (paddr == OFS_CMD);
  assign cmd_state = pwr_state_type'(pwdata[2:0]);
  assign slp_sel   = pwr_state_type'(ctrl_r[CTRL_SLP_LSB +: 3]);

  // ------------------------------------------------------------
  // Switch hold timing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      hold_r  <= '0;
      btn_q_r <= 1'b0;
    end else begin
      btn_q_r <= btn;
      if (!btn)
        hold_r <= '0;
      else if (hold_r <= HOLD_W'(LONG_HOLD))
        hold_r <= hold_r + 1'b1;
    end
  end

  assign short_rel = btn_q_r & ~btn & (hold_r < HOLD_W'(SHORT_HOLD)) & ~long_done_r;
  assign long_hit  = btn & (hold_r == HOLD_W'(LONG_HOLD));

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in)
      long_done_r <= 1'b0;
    else if (long_hit)
      long_done_r <= 1'b1;
    else if (!btn)
      long_done_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // Wake sources
  // ------------------------------------------------------------
  always_comb begin
    wake_any = 1'b0;
    if (is_sleep(state_r) || state_r == ST_S5)
      wake_any = wake_s.rtc_alarm | wake_s.lan | ~wake_s.wake_n;
    if ((is_sleep(state_r) || state_r == ST_S5) && ctrl_r[CTRL_PME_EN])
      wake_any = wake_any | ~wake_s.pme_n;
    if (state_r == ST_S1 || state_r == ST_S3)
      wake_any = wake_any | wake_s.usb;
    if (state_r == ST_S3 || state_r == ST_S4 || state_r == ST_S5)
      wake_any = wake_any | wake_s.cir;
    wake_any = wake_any & wake_gate(state_r, ctrl_r[CTRL_S4_EN]);
  end

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_S0: begin
        if (long_hit)
          state_nxt = ST_S5;
        else if (short_rel)
          state_nxt = slp_sel;
        else if (cmd_wr && cmd_state inside {ST_S1, ST_S3, ST_S4, ST_S5})
          state_nxt = cmd_state;
      end
      ST_S1, ST_S3, ST_S4: begin
        if (long_hit)
          state_nxt = ST_S5;
        else if ((short_rel && wake_gate(state_r, ctrl_r[CTRL_S4_EN])) || wake_any)
          state_nxt = ST_S0;
        else if (cmd_wr && cmd_state == ST_S5)
          state_nxt = ST_S5;
      end
      ST_S5: begin
        if (short_rel || wake_any)
          state_nxt = ST_S0;
      end
      default: state_nxt = ST_S5;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in)
      state_r <= ST_S5;
    else
      state_r <= state_nxt;
  end

  // ------------------------------------------------------------
  // Power outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pwr_ctl_out <= '0;
    end else begin
      pwr_ctl_out.main_pwr_en <= (state_nxt == ST_S0) || (state_nxt == ST_S1);
      pwr_ctl_out.dev_pwr_en  <= (state_nxt == ST_S0) || (state_nxt == ST_S1);
      pwr_ctl_out.cpu_run     <= (state_nxt == ST_S0);
      pwr_ctl_out.cold_boot   <= (state_r == ST_S5) && (state_nxt == ST_S0);
    end
  end

  assign state_out = state_r;

  // ------------------------------------------------------------
  // Fan control
  // ------------------------------------------------------------
  logic [7:0]      div_r;
  logic [7:0]      pwm_cnt_r;
  logic [FANS-1:0] fan_run;
  logic            pwm_tick;

  assign pwm_tick = (div_r == PWM_DIV);
  assign fan_run  = {FANS{(state_r == ST_S0) || (state_r == ST_S1)}};

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      div_r     <= '0;
      pwm_cnt_r <= '0;
    end else begin
      div_r <= pwm_tick ? 8'h00_00 : div_r + 1'b1;
      if (pwm_tick)
        pwm_cnt_r <= pwm_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      fan_pwm_out <= '0;
    end else begin
      for (int i = 0; i < FANS; i++)
        fan_pwm_out[i] <= fan_run[i] & (pwm_cnt_r < fan_duty(fan_temp_in[i], fan_on_r));
    end
  end

  // ------------------------------------------------------------
  // Rail monitor and intrusion
  // ------------------------------------------------------------
  // window check
  always_comb begin
    for (int i = 0; i < RAILS; i++)
      rail_bad[i] = (rail_level_in[i] < RAIL_LO[i]) || (rail_level_in[i] > RAIL_HI[i]);
  end

  always_comb begin
    irq_set             = '0;
    irq_set[IRQ_WAKE]   = (state_r != ST_S0) && (state_nxt == ST_S0);
    irq_set[IRQ_RAIL]   = |rail_bad;
    irq_set[IRQ_INTRUD] = chassis_s;
    irq_set[IRQ_FORCED] = long_hit;
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ctrl_r   <= CTRL_RST;
      fan_on_r <= FAN_ON_RST;
      irq_en_r <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL)
        ctrl_r <= pwdata[7:0];
      if (paddr == OFS_FAN_CFG)
        fan_on_r <= pwdata[7:0];
      if (paddr == OFS_IRQ_EN)
        irq_en_r <= pwdata[IRQ_W-1:0];
    end
  end

  // Set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in)
      irq_stat_r <= '0;
    else if (wr_en && paddr == OFS_IRQ_CLR)
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_stat_r & irq_en_r);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      prdata <= '0;
    end else if (rd_en) begin
      case (paddr)
        OFS_CTRL:     prdata <= {24'h0000_00, ctrl_r};
        OFS_STATUS:   prdata <= {16'h0000, 3'b000, rail_bad, 5'b0_0000, state_r};
        OFS_IRQ_STAT: prdata <= {28'h000_0000, irq_stat_r};
        OFS_IRQ_EN:   prdata <= {28'h000_0000, irq_en_r};
        OFS_FAN_CFG:  prdata <= {24'h0000_00, fan_on_r};
        default:      prdata <= '0;
      endcase
    end
  end
endmodule

// [pkg/pwr_seq_pkg.sv]
/*
 Package for the power button and wake sequencer: states, register map,
 interrupt bit layout, hold times and the structs that carry pin groups.
 Assumes one 125 MHz standby clock and an APB master for software.
*/
// Contract
// - From soft-off, a hold under four seconds powers up to working.
// - From working, a hold under four seconds enters the selected sleep state.
// - From working, a hold beyond six seconds forces soft-off regardless of software.
// - From sleep, a hold under four seconds wakes to working.
// - From sleep, a hold beyond six seconds goes straight to soft-off.
// - Switch, alarm, LAN, PME and WAKE wake from S1, S3, S4, S5; S4 needs OS support.
// - USB activity wakes only from S1 and S3.
// - Infrared activity wakes only from S3, S4 and S5.
// - PME wakes only while its wake enable setting is on.
// - Each of three fans is speed controlled or switched by its temperature.
// - Fans run only in S0 and S1, held off otherwise.
// - Five rails are checked and flagged when outside their window.
// - A closed chassis switch records an intrusion event.
// - A software command powers the system off without the switch.
// - S3, S4, S5 remove device power; leaving S5 performs a cold boot.
package pwr_seq_pkg;

  typedef enum logic [2:0] {
    ST_S0 = 3'b000,
    ST_S1 = 3'b001,
    ST_S3 = 3'b011,
    ST_S4 = 3'b100,
    ST_S5 = 3'b101
  } pwr_state_type;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 125000;
  localparam int unsigned SHORT_MS     = 4000;
  localparam int unsigned LONG_MS      = 6000;
  localparam int unsigned SHORT_CYC    = SHORT_MS * CLK_KHZ;
  localparam int unsigned LONG_CYC     = LONG_MS * CLK_KHZ;
  localparam int unsigned HOLD_W       = 32;
  localparam logic [7:0]  PWM_DIV      = 8'h00_7C;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00_00;
  localparam logic [7:0] OFS_CMD      = 8'h00_04;
  localparam logic [7:0] OFS_STATUS   = 8'h00_08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h00_0C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h00_10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h00_14;
  localparam logic [7:0] OFS_FAN_CFG  = 8'h00_18;

  // Control fields
  localparam int CTRL_PME_EN  = 0;
  localparam int CTRL_S4_EN   = 1;
  localparam int CTRL_SLP_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h00_30;

  // Fan start temperature and gain shift
  localparam logic [7:0] FAN_ON_RST = 8'h00_28;
  localparam int         FAN_GAIN   = 2;

  // Interrupt bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_WAKE   = 0;
  localparam int IRQ_RAIL   = 1;
  localparam int IRQ_INTRUD = 2;
  localparam int IRQ_FORCED = 3;

  // Rail windows: +5, +12, +3.3 standby, +1.1, core
  localparam int RAILS = 5;
  localparam int FANS  = 3;
  localparam logic [RAILS-1:0][7:0] RAIL_LO = {8'h00_A0, 8'h00_A0, 8'h00_B0,
                                               8'h00_B0, 8'h00_B0};
  localparam logic [RAILS-1:0][7:0] RAIL_HI = {8'h00_E0, 8'h00_E0, 8'h00_D0,
                                               8'h00_D0, 8'h00_D0};

  typedef struct packed {
    logic rtc_alarm;
    logic lan;
    logic usb;
    logic pme_n;
    logic wake_n;
    logic cir;
  } wake_pins_type;

  typedef struct packed {
    logic main_pwr_en;
    logic dev_pwr_en;
    logic cpu_run;
    logic cold_boot;
  } pwr_ctl_type;

endpackage

// [core/sync_2ff.sv]
/*
 Two flip-flop synchroniser for a group of asynchronous levels.
 Assumes the inputs change slowly compared with the clock.
*/
`timescale 1ns/10ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      meta_r   <= rst_val_in;
      sync_out <= rst_val_in;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// [test/power_button_wake_sequencer_asserts.sv]
/*
 Port checker for the power sequencer.
 Assumes it is bound onto the top module, one clock domain.
*/
`timescale 1ns/10ps
module power_button_wake_sequencer_asserts (
  input wire logic                       sys_clk_in,
  input wire logic                       reset_n_in,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       pwr_btn_n_in,
  input wire pwr_seq_pkg::wake_pins_type wake_pins_in,
  input wire pwr_seq_pkg::pwr_state_type state_out,
  input wire pwr_seq_pkg::pwr_ctl_type   pwr_ctl_out,
  input wire logic [2:0]                 fan_pwm_out
);
  import pwr_seq_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic access, mapped, quiet, act, off;
  assign access = psel && penable;
  assign mapped = paddr inside {OFS_CTRL, OFS_CMD, OFS_STATUS, OFS_IRQ_STAT,
                                OFS_IRQ_CLR, OFS_IRQ_EN, OFS_FAN_CFG};
  assign quiet  = pwr_btn_n_in && !psel;
  assign act    = wake_pins_in.rtc_alarm || wake_pins_in.lan || !wake_pins_in.wake_n;
  assign off    = state_out inside {ST_S3, ST_S4, ST_S5};
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_wake_held;
    (state_out inside {ST_S1, ST_S3, ST_S5} && act && quiet) ##1 (act && quiet) ##1
    (act && quiet);
  endsequence
  sequence s_usb_held;
    (state_out inside {ST_S4, ST_S5} && wake_pins_in == 6'h0E && quiet) [*5];
  endsequence
  sequence s_cir_held;
    (state_out == ST_S1 && wake_pins_in == 6'h07 && quiet) [*5];
  endsequence
  a_wake_accept: assert property (s_wake_held |-> ##[1:3] state_out == ST_S0)
    else $error("wake source ignored");
  a_usb_refused: assert property (s_usb_held |=> $stable(state_out))
    else $error("usb woke a deep state");
  a_cir_refused: assert property (s_cir_held |=> $stable(state_out))
    else $error("infrared woke from S1");
  a_fans_off: assert property (off && $stable(state_out) |-> fan_pwm_out == 3'h0)
    else $error("fan running while off");
  a_power_removed: assert property (off && $stable(state_out)
    |-> !pwr_ctl_out.main_pwr_en && !pwr_ctl_out.dev_pwr_en) else $error("power left on");
  a_power_on: assert property (state_out == ST_S0 && $stable(state_out)
    |-> pwr_ctl_out.main_pwr_en && pwr_ctl_out.cpu_run) else $error("working without power");
  a_cold_boot: assert property (state_out == ST_S0 && $past(state_out) == ST_S5
    |-> $rose(pwr_ctl_out.cold_boot) ##1 !pwr_ctl_out.cold_boot) else $error("no boot pulse");
  a_soft_off: assert property (access && pwrite && paddr == OFS_CMD
    && pwdata[2:0] == 3'h5 && state_out == ST_S0 |-> ##[1:3] state_out == ST_S5)
    else $error("soft off not taken");
  a_off_exit: assert property (state_out == ST_S5
    |=> state_out inside {ST_S5, ST_S0}) else $error("soft off left to a sleep state");
  a_slverr_map: assert property (access |-> pslverr == !mapped)
    else $error("slave error on wrong address");
endmodule

// [test/panel_wake_model.sv]
/*
 Panel switch and wake source model.
 Assumes its tasks are called from one bench process.
*/
`timescale 1ns/10ps
module panel_wake_model (
  input  wire logic                  sys_clk_in,
  output logic                       pwr_btn_n_out,
  output pwr_seq_pkg::wake_pins_type wake_pins_out
);
  import pwr_seq_pkg::*;
  // Released switch, idle wake lines
  initial begin
    pwr_btn_n_out = 1'b1;
    wake_pins_out = 6'h06;
  end
  task automatic press(input int n);
    @(posedge sys_clk_in);
    pwr_btn_n_out <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    pwr_btn_n_out <= 1'b1;
  endtask
  task automatic wake(input logic [5:0] w, input int n);
    @(posedge sys_clk_in);
    wake_pins_out <= w;
    repeat (n) @(posedge sys_clk_in);
    wake_pins_out <= 6'h06;
  endtask
endmodule

// [test/power_button_wake_sequencer_tb.sv]
/*
 Self-checking bench for the power sequencer.
 Assumes the panel model and the port checker.
*/
`timescale 1ns/10ps
module power_button_wake_sequencer_tb;
  import pwr_seq_pkg::*;
  logic            sys_clk_in, reset_n_in, psel, penable, pwrite, pready;
  logic            pslverr, err, irq_out, pwr_btn_n, chassis;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, q;
  logic [2:0][7:0] temp;
  logic [4:0][7:0] rail;
  logic [2:0]      pwm;
  wake_pins_type   pins;
  pwr_state_type   state;
  pwr_ctl_type     ctl;
  int              n_errors, checks, hi [3];
  panel_wake_model u_panel (.sys_clk_in(sys_clk_in), .pwr_btn_n_out(pwr_btn_n),
                            .wake_pins_out(pins));
  power_button_wake_sequencer #(.SHORT_HOLD(20), .LONG_HOLD(40)) DUT (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwr_btn_n_in(pwr_btn_n), .wake_pins_in(pins),
    .chassis_closed_in(chassis), .fan_temp_in(temp), .rail_level_in(rail),
    .state_out(state), .pwr_ctl_out(ctl), .fan_pwm_out(pwm), .irq_out(irq_out));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_st(input string what, input pwr_state_type exp);
    checks++;
    if (state !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, state);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_errors++;
      results();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input string what);
    apb(1'b0, a, 32'h0);
    chk_w(what, e, q & m);
  endtask
  task automatic irq_is(input logic e, input string what);
    repeat (2) @(posedge sys_clk_in);
    chk_w(what, {31'h0, e}, {31'h0, irq_out});
  endtask
  task automatic wait_st(input pwr_state_type exp, input string what);
    int i;
    for (i = 0; i < 200 && state !== exp; i++) @(posedge sys_clk_in);
    chk_st(what, exp);
    if (i == 200) results();
  endtask
  task automatic enter(input pwr_state_type s);
    if (state !== ST_S0) begin
      u_panel.press(8);
      wait_st(ST_S0, "back to working");
    end
    apb(1'b1, OFS_CMD, {29'h0, s});
    wait_st(s, "command entry");
  endtask
  task automatic count_pwm(input int n);
    hi = '{0, 0, 0};
    repeat (n) begin
      @(posedge sys_clk_in);
      for (int f = 0; f < FANS; f++) hi[f] += (pwm[f] === 1'b1);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OFS_CTRL, 32'hFF, {24'h0, CTRL_RST}, "ctrl reset");
    rd_chk(OFS_FAN_CFG, 32'hFF, {24'h0, FAN_ON_RST}, "fan cfg reset");
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped data");
    chk_w("unmapped error", 32'h1, {31'h0, err});
    rd_chk(OFS_CMD, 32'hFFFF_FFFF, 32'h0, "cmd read");
    apb(1'b1, OFS_CTRL, 32'h33);
    $display("test regs done");
  endtask
  task automatic t_button();
    u_panel.press(8);
    wait_st(ST_S0, "short from off");
    u_panel.press(8);
    wait_st(ST_S3, "short from working");
    u_panel.press(8);
    wait_st(ST_S0, "short from sleep");
    u_panel.press(30);
    repeat (20) @(posedge sys_clk_in);
    chk_st("middle hold", ST_S0);
    apb(1'b1, OFS_IRQ_CLR, 32'hF);
    u_panel.press(50);
    wait_st(ST_S5, "long from working");
    rd_chk(OFS_IRQ_STAT, 32'h8, 32'h8, "forced flag");
    enter(ST_S3);
    u_panel.press(50);
    wait_st(ST_S5, "long from sleep");
    $display("test button done");
  endtask
  task automatic t_wake();
    pwr_state_type sl [4];
    logic ok;
    sl = '{ST_S1, ST_S3, ST_S4, ST_S5};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        enter(sl[k]);
        ok = (i == 2) ? (k < 2) : (i == 5) ? (k > 0) : 1'b1;
        u_panel.wake(6'h06 ^ (6'h20 >> i), 12);
        repeat (6) @(posedge sys_clk_in);
        chk_st("wake source", ok ? ST_S0 : sl[k]);
      end
    end
    apb(1'b1, OFS_CTRL, 32'h32);
    enter(ST_S3);
    u_panel.wake(6'h02, 12);
    repeat (6) @(posedge sys_clk_in);
    chk_st("pme disabled", ST_S3);
    apb(1'b1, OFS_CTRL, 32'h33);
    $display("test wake done");
  endtask
  task automatic t_irq();
    apb(1'b1, OFS_CTRL, 32'h13);
    enter(ST_S0);
    u_panel.press(8);
    wait_st(ST_S1, "short to chosen sleep");
    apb(1'b1, OFS_IRQ_CLR, 32'hF);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    irq_is(1'b0, "irq idle");
    u_panel.press(8);
    wait_st(ST_S0, "wake from S1");
    irq_is(1'b1, "irq raised");
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    irq_is(1'b0, "irq masked");
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    irq_is(1'b1, "irq unmasked");
    apb(1'b1, OFS_IRQ_CLR, 32'h1);
    irq_is(1'b0, "irq cleared");
    $display("test irq done");
  endtask
  task automatic t_mon();
    for (int k = 0; k < RAILS; k++) begin
      rail[k] <= RAIL_HI[k] + 8'h01;
      repeat (4) @(posedge sys_clk_in);
      rd_chk(OFS_STATUS, 32'h1F00, 32'h100 << k, "rail above");
      rail[k] <= RAIL_LO[k] - 8'h01;
      repeat (4) @(posedge sys_clk_in);
      rd_chk(OFS_STATUS, 32'h1F00, 32'h100 << k, "rail below");
      rail[k] <= 8'hC0;
    end
    rd_chk(OFS_IRQ_STAT, 32'h2, 32'h2, "rail flag");
    rd_chk(OFS_STATUS, 32'h1F00, 32'h0, "rails inside");
    apb(1'b1, OFS_IRQ_CLR, 32'hF);
    rd_chk(OFS_IRQ_STAT, 32'h4, 32'h0, "cover fitted");
    chassis <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4, "intrusion flag");
    chassis <= 1'b0;
    $display("test monitor done");
  endtask
  task automatic t_fan();
    temp <= {8'hFF, 8'h50, 8'h10};
    count_pwm(32000);
    chk_w("fan below start", 32'h0, hi[0]);
    chk_w("fan warm runs", 32'h1, {31'h0, hi[1] > 0});
    chk_w("fan hot faster", 32'h1, {31'h0, hi[2] > hi[1]});
    enter(ST_S3);
    count_pwm(2000);
    chk_w("fans in S3", 32'h0, hi[0] + hi[1] + hi[2]);
    enter(ST_S1);
    count_pwm(2000);
    chk_w("fans in S1", 32'h1, {31'h0, hi[2] > 0});
    apb(1'b1, OFS_FAN_CFG, 32'h60);
    repeat (2) @(posedge sys_clk_in);
    count_pwm(2000);
    chk_w("fan start raised", 32'h0, hi[1]);
    chk_w("hot fan still runs", 32'h1, {31'h0, hi[2] > 0});
    $display("test fan done");
  endtask
  initial begin
    reset_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    chassis = 1'b0;
    temp = '0;
    rail = {5{8'hC0}};
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk_st("reset state", ST_S5);
    t_regs();
    t_button();
    t_wake();
    t_irq();
    t_mon();
    t_fan();
    results();
  end
endmodule
bind power_button_wake_sequencer power_button_wake_sequencer_asserts u_asserts (
  .sys_clk_in, .reset_n_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .pwr_btn_n_in, .wake_pins_in, .state_out, .pwr_ctl_out, .fan_pwm_out);
